// ===== rtl/sdg_pkg.sv
// Constants for the socket detect and global control register pair.
// Assumes a byte-wide legacy register port addressed by socket offset.
package sdg_pkg;

  // Register offsets on the legacy socket register port
  localparam logic [7:0] SDG_DETECT_CTRL_OFFSET = 8'h16;
  localparam logic [7:0] SDG_GLOBAL_CTRL_OFFSET = 8'h1E;

  // Detect/control register field positions
  localparam int unsigned SDG_DC_VS_TWO_BIT     = 7;
  localparam int unsigned SDG_DC_VS_ONE_BIT     = 6;
  localparam int unsigned SDG_DC_SOFT_IRQ_BIT   = 5;
  localparam int unsigned SDG_DC_RESUME_BIT     = 4;
  localparam int unsigned SDG_DC_RST_REMOVE_BIT = 1;

  // Global control register field positions
  localparam int unsigned SDG_GC_SECOND_LVL_BIT = 4;
  localparam int unsigned SDG_GC_FIRST_LVL_BIT  = 3;
  localparam int unsigned SDG_GC_CLEAR_SEL_BIT  = 2;
  localparam int unsigned SDG_GC_CSC_LVL_BIT    = 1;
  localparam int unsigned SDG_GC_PWR_DOWN_BIT   = 0;

  // Reset values of the writable bits
  localparam logic SDG_RESUME_RESET     = 1'b0;
  localparam logic SDG_RST_REMOVE_RESET = 1'b0;
  localparam logic SDG_GC_BIT_RESET     = 1'b0;

  // Value returned for unmapped offsets and reserved bits
  localparam logic [7:0] SDG_READ_ZERO = 8'h00;

  // Read data is returned this many cycles after the request
  localparam int unsigned SDG_READ_LATENCY = 1;

endpackage : sdg_pkg

// ===== rtl/sdg_detect_monitor.sv
// Card detect change, removal detection and ring-indicate resume latch.
// Assumes card detect pins and the status flag are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module sdg_detect_monitor
  import sdg_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic cardDetectOne_n,     // Low while card seated
  input  wire logic cardDetectTwo_n,     // Low while card seated
  input  wire logic detectResumeEnable,  // Resume enable bit
  input  wire logic statusChangeFlag,    // Card status change flag
  output logic      detectChange,        // Pulse on any detect change
  output logic      cardRemoved,         // Pulse on seated to unseated
  output logic      ringIndicateOutput_n // Resume output, low = wake
);

  logic cdOnePrev_reg;   // Last detect samples
  logic cdTwoPrev_reg;
  logic primed_reg;      // Suppresses a false change after reset
  logic flagPrev_reg;    // For spotting the flag being cleared
  logic change;
  logic flagCleared;

  assign change      = primed_reg &&
                       ((cdOnePrev_reg != cardDetectOne_n) ||
                        (cdTwoPrev_reg != cardDetectTwo_n));
  assign flagCleared = flagPrev_reg && !statusChangeFlag;

  // Sample history; the first cycle only primes the history
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cdOnePrev_reg <= 1'b1;
      cdTwoPrev_reg <= 1'b1;
      primed_reg    <= 1'b0;
      flagPrev_reg  <= 1'b0;
    end
    else
    begin
      cdOnePrev_reg <= cardDetectOne_n;
      cdTwoPrev_reg <= cardDetectTwo_n;
      primed_reg    <= 1'b1;
      flagPrev_reg  <= statusChangeFlag;
    end
  end

  // Event pulses; removal means both were seated and one lifted
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      detectChange <= 1'b0;
      cardRemoved  <= 1'b0;
    end
    else
    begin
      detectChange <= change;
      cardRemoved  <= primed_reg && !cdOnePrev_reg && !cdTwoPrev_reg &&
                      (cardDetectOne_n || cardDetectTwo_n);
    end
  end

  // Resume latch, kept in its active-low form so the pin comes from a
  // flop; a new change wins over a flag clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ringIndicateOutput_n <= 1'b1;
    else if (change && detectResumeEnable)
      ringIndicateOutput_n <= 1'b0;                     // RULE_06
    else if (flagCleared)
      ringIndicateOutput_n <= 1'b1;                     // RULE_07
  end

  a_ring_goes_low: assert property (@(posedge clk) disable iff (!reset_n)
    change && detectResumeEnable |=> !ringIndicateOutput_n) // RULE_06
    else $error("Ring indicate did not fall on detect change");

  a_ring_held_low: assert property (@(posedge clk) disable iff (!reset_n)
    !ringIndicateOutput_n && !flagCleared |=> !ringIndicateOutput_n) // RULE_07
    else $error("Ring indicate released before flag clear");

endmodule // sdg_detect_monitor
`default_nettype wire

// ===== rtl/sdg_power_gate.sv
// Card-side output enable gating for the power-down mode.
// Assumes cardCycleActive is high for each cycle of a card access.
`timescale 1ns/100ps
`default_nettype none
module sdg_power_gate
  import sdg_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic cardPowerDown,    // Power-down mode enabled
  input  wire logic cardCycleActive,  // Card access in progress
  output logic      cardOutputEnable_n // Low = card outputs driven
);

  // In power-down, float the card pins unless an access runs; the enable lags the
  // access by one clock, so the access logic must allow that much setup
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cardOutputEnable_n <= 1'b0;
    else
      cardOutputEnable_n <= cardPowerDown && !cardCycleActive; // RULE_15
  end

  a_power_floats: assert property (@(posedge clk) disable iff (!reset_n)
    cardPowerDown && !cardCycleActive |=> cardOutputEnable_n) // RULE_15
    else $error("Card outputs driven while powered down and idle");

  a_access_wakes: assert property (@(posedge clk) disable iff (!reset_n)
    cardCycleActive |=> !cardOutputEnable_n) // RULE_16
    else $error("Card access did not wake the interface");

endmodule // sdg_power_gate
`default_nettype wire

// ===== rtl/sdg_socket_detect_global_ctrl.sv
// Socket detect/control and global control registers of one socket.
// Assumes a byte-wide register port synchronous to clk; card pins are
// sampled directly as they are already synchronous.
//
// Overview of operation
// RULE_01 - Bit 7 reads second voltage-sense pin live
// RULE_02 - Bit 6 reads first voltage-sense pin live
// RULE_03 - Writing bit 5 raises card-detect interrupt
// RULE_04 - No interrupt when card-detect enable clear
// RULE_05 - Soft card-detect bit always reads zero
// RULE_06 - Resume enable: detect change pulls ring low
// RULE_07 - Ring stays low until status flag cleared
// RULE_08 - Bit 1 resets registers on card removal
// RULE_09 - Detect register bits 3,2,0 read zero
// RULE_10 - Global register bits 7 to 5 read zero
// RULE_11 - Bit 4 selects second card interrupt level
// RULE_12 - Bit 3 selects first card interrupt level
// RULE_13 - Bit 2 selects flag clear by read/write
// RULE_14 - Bit 1 selects status-change interrupt level
// RULE_15 - Power-down floats card outputs between accesses
// RULE_16 - Power-down still takes interrupts; access wakes
// RULE_17 - Reset clears all writable bits
`timescale 1ns/100ps
`default_nettype none
module sdg_socket_detect_global_ctrl
  import sdg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Host register port
  input  wire logic       regSelect,       // Access strobe, one cycle
  input  wire logic       regWrite,        // 1 = write, 0 = read
  input  wire logic [7:0] regAddr,         // Socket register offset
  input  wire logic [7:0] regWriteData,
  output logic      [7:0] regReadData,     // Valid with regReadValid
  output logic            regReadValid,    // One-cycle pulse
  // Card-side pins
  input  wire logic       voltageSenseOnePin,
  input  wire logic       voltageSenseTwoPin,
  input  wire logic       cardDetectOne_n,
  input  wire logic       cardDetectTwo_n,
  input  wire logic       cardCycleActive,
  output logic            cardOutputEnable_n,
  output logic            ringIndicateOutput_n,
  // Neighbouring status-change logic
  input  wire logic       cardDetectIrqEnable,
  input  wire logic       statusChangeFlag,
  output logic            softCardDetectIrq,  // One-cycle pulse
  output logic            cardDetectChange,   // One-cycle pulse
  output logic            legacyRegsReset,    // One-cycle pulse
  // Mode outputs to the interrupt and flag logic
  output logic            secondCardIrqLevelSel,
  output logic            firstCardIrqLevelSel,
  output logic            flagClearMethodSel,
  output logic            statusChangeIrqLevelSel,
  output logic            cardPowerDown
);

  // Writable state of the detect/control register
  logic detectResumeEnable_reg;  // Resume signalling enable
  logic resetOnRemoval_reg;      // Reset registers when card pulled

  // Writable state of the global control register
  logic secondLevel_reg;         // Second card interrupt mode
  logic firstLevel_reg;          // First card interrupt mode
  logic clearSel_reg;            // Status flag clear method
  logic cscLevel_reg;            // Status change interrupt mode
  logic powerDown_reg;           // Card interface power-down

  // Decoded accesses
  logic writeDetect;
  logic writeGlobal;
  logic readAccess;
  logic cardRemoved;             // Removal pulse from the monitor
  logic removalReset;            // Removal with reset enabled
  logic [7:0] readData_next;     // Read mux output

  // Match an access against one register offset
  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] offset);
    return addr == offset;
  endfunction

  assign writeDetect  = regSelect && regWrite &&
                        hits(regAddr, SDG_DETECT_CTRL_OFFSET);
  assign writeGlobal  = regSelect && regWrite &&
                        hits(regAddr, SDG_GLOBAL_CTRL_OFFSET);
  assign readAccess   = regSelect && !regWrite;
  assign removalReset = cardRemoved && resetOnRemoval_reg; // RULE_08

  // Detect/control writable bits; a removal reset beats a host write
  // because the card is gone and stale settings must not survive it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      detectResumeEnable_reg <= SDG_RESUME_RESET;       // RULE_17
      resetOnRemoval_reg     <= SDG_RST_REMOVE_RESET;   // RULE_17
    end
    else if (removalReset)
    begin
      detectResumeEnable_reg <= SDG_RESUME_RESET;       // RULE_08
      resetOnRemoval_reg     <= SDG_RST_REMOVE_RESET;   // RULE_08
    end
    else if (writeDetect)
    begin
      detectResumeEnable_reg <= regWriteData[SDG_DC_RESUME_BIT];
      resetOnRemoval_reg     <= regWriteData[SDG_DC_RST_REMOVE_BIT];
    end
  end

  // Global control writable bits, reset the same way
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      secondLevel_reg <= SDG_GC_BIT_RESET;              // RULE_17
      firstLevel_reg  <= SDG_GC_BIT_RESET;
      clearSel_reg    <= SDG_GC_BIT_RESET;
      cscLevel_reg    <= SDG_GC_BIT_RESET;
      powerDown_reg   <= SDG_GC_BIT_RESET;
    end
    else if (removalReset)
    begin
      secondLevel_reg <= SDG_GC_BIT_RESET;              // RULE_08
      firstLevel_reg  <= SDG_GC_BIT_RESET;
      clearSel_reg    <= SDG_GC_BIT_RESET;
      cscLevel_reg    <= SDG_GC_BIT_RESET;
      powerDown_reg   <= SDG_GC_BIT_RESET;
    end
    else if (writeGlobal)
    begin
      secondLevel_reg <= regWriteData[SDG_GC_SECOND_LVL_BIT]; // RULE_11
      firstLevel_reg  <= regWriteData[SDG_GC_FIRST_LVL_BIT];  // RULE_12
      clearSel_reg    <= regWriteData[SDG_GC_CLEAR_SEL_BIT];  // RULE_13
      cscLevel_reg    <= regWriteData[SDG_GC_CSC_LVL_BIT];    // RULE_14
      powerDown_reg   <= regWriteData[SDG_GC_PWR_DOWN_BIT];   // RULE_15
    end
  end

  // Mode bits go straight from their flops to the consuming logic
  assign secondCardIrqLevelSel   = secondLevel_reg;     // RULE_11
  assign firstCardIrqLevelSel    = firstLevel_reg;      // RULE_12
  assign flagClearMethodSel      = clearSel_reg;        // RULE_13
  assign statusChangeIrqLevelSel = cscLevel_reg;        // RULE_14
  assign cardPowerDown           = powerDown_reg;       // RULE_15

  // Soft card-detect request: not stored, so nothing reads back;
  // it does not look at power-down, so interrupts still flow then
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      softCardDetectIrq <= 1'b0;
    else
      softCardDetectIrq <= writeDetect && cardDetectIrqEnable &&
                           regWriteData[SDG_DC_SOFT_IRQ_BIT]; // RULE_03 RULE_04 RULE_16
  end

  // Removal reset pulse towards the other socket registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      legacyRegsReset <= 1'b0;
    else
      legacyRegsReset <= removalReset;                  // RULE_08
  end

  // Read mux; reserved bits and unmapped offsets return zero
  always_comb
  begin
    readData_next = SDG_READ_ZERO;                      // RULE_09 RULE_10
    if (hits(regAddr, SDG_DETECT_CTRL_OFFSET))
    begin
      readData_next[SDG_DC_VS_TWO_BIT]     = voltageSenseTwoPin;  // RULE_01
      readData_next[SDG_DC_VS_ONE_BIT]     = voltageSenseOnePin;  // RULE_02
      readData_next[SDG_DC_SOFT_IRQ_BIT]   = 1'b0;                // RULE_05
      readData_next[SDG_DC_RESUME_BIT]     = detectResumeEnable_reg;
      readData_next[SDG_DC_RST_REMOVE_BIT] = resetOnRemoval_reg;
    end
    else if (hits(regAddr, SDG_GLOBAL_CTRL_OFFSET))
    begin
      readData_next[SDG_GC_SECOND_LVL_BIT] = secondLevel_reg;
      readData_next[SDG_GC_FIRST_LVL_BIT]  = firstLevel_reg;
      readData_next[SDG_GC_CLEAR_SEL_BIT]  = clearSel_reg;
      readData_next[SDG_GC_CSC_LVL_BIT]    = cscLevel_reg;
      readData_next[SDG_GC_PWR_DOWN_BIT]   = powerDown_reg;
    end
  end

  // Read answer one cycle after the strobe; data holds until next read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regReadData  <= SDG_READ_ZERO;
      regReadValid <= 1'b0;
    end
    else
    begin
      regReadValid <= readAccess;
      if (readAccess)
        regReadData <= readData_next;
    end
  end

  // Card detect change, removal and resume output
  sdg_detect_monitor u_detect
  (
    .clk                  (clk),
    .reset_n              (reset_n),
    .cardDetectOne_n      (cardDetectOne_n),
    .cardDetectTwo_n      (cardDetectTwo_n),
    .detectResumeEnable   (detectResumeEnable_reg),
    .statusChangeFlag     (statusChangeFlag),
    .detectChange         (cardDetectChange),
    .cardRemoved          (cardRemoved),
    .ringIndicateOutput_n (ringIndicateOutput_n)
  );

  // Power-down gating of the card-side outputs
  sdg_power_gate u_power
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .cardPowerDown      (powerDown_reg),
    .cardCycleActive    (cardCycleActive),
    .cardOutputEnable_n (cardOutputEnable_n)
  );

  // Helper: last read targeted the detect register
  logic readWasDetect_reg;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      readWasDetect_reg <= 1'b0;
    else if (readAccess)
      readWasDetect_reg <= hits(regAddr, SDG_DETECT_CTRL_OFFSET);
  end

  a_vs_two_read: assert property (@(posedge clk) disable iff (!reset_n)
    readAccess && hits(regAddr, SDG_DETECT_CTRL_OFFSET) |=>
      regReadData[SDG_DC_VS_TWO_BIT] == $past(voltageSenseTwoPin)) // RULE_01
    else $error("Second voltage-sense level misreported");

  a_vs_one_read: assert property (@(posedge clk) disable iff (!reset_n)
    readAccess && hits(regAddr, SDG_DETECT_CTRL_OFFSET) |=>
      regReadData[SDG_DC_VS_ONE_BIT] == $past(voltageSenseOnePin)) // RULE_02
    else $error("First voltage-sense level misreported");

  a_soft_irq_fires: assert property (@(posedge clk) disable iff (!reset_n)
    writeDetect && cardDetectIrqEnable &&
      regWriteData[SDG_DC_SOFT_IRQ_BIT] |=> softCardDetectIrq ##1
      !softCardDetectIrq) // RULE_03
    else $error("Soft card-detect write gave no single pulse");

  a_soft_irq_gated: assert property (@(posedge clk) disable iff (!reset_n)
    softCardDetectIrq |-> $past(cardDetectIrqEnable) && $past(writeDetect))
    // RULE_04
    else $error("Soft card-detect pulse without enable");

  a_soft_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
    regReadValid |-> !regReadData[SDG_DC_SOFT_IRQ_BIT]) // RULE_05
    else $error("Soft card-detect bit read back as one");

  a_removal_clears: assert property (@(posedge clk) disable iff (!reset_n)
    cardRemoved && resetOnRemoval_reg |=> legacyRegsReset &&
      !resetOnRemoval_reg && !detectResumeEnable_reg && !powerDown_reg)
    // RULE_08
    else $error("Removal did not reset the registers");

  a_removal_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    cardRemoved && !resetOnRemoval_reg && !writeGlobal |=>
      !legacyRegsReset && $stable(powerDown_reg)) // RULE_08
    else $error("Removal changed registers while reset disabled");

  a_dc_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    regReadValid && readWasDetect_reg |->
      regReadData[3:2] == 2'h0 && !regReadData[0]) // RULE_09
    else $error("Detect register reserved bits not zero");

  a_gc_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    regReadValid |-> regReadData[7:5] == 3'h0 || readWasDetect_reg)
    // RULE_10
    else $error("Global register reserved bits not zero");

  a_mode_write: assert property (@(posedge clk) disable iff (!reset_n)
    writeGlobal && !removalReset |=>
      {secondCardIrqLevelSel, firstCardIrqLevelSel, flagClearMethodSel,
       statusChangeIrqLevelSel} == $past(regWriteData[4:1]))
    // RULE_11 RULE_12 RULE_13 RULE_14
    else $error("Mode bits did not take the written value");

endmodule // sdg_socket_detect_global_ctrl
`default_nettype wire

// ===== verif/sdg_card_model.sv
// Behavioural PC Card as seen at the socket's detect and sense pins.
// Assumes the bench changes its controls just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module sdg_card_model
(
  input  wire logic seated,             // Card fully inserted
  input  wire logic vsOneCode,          // Voltage key of the card, line one
  input  wire logic vsTwoCode,          // Voltage key of the card, line two
  output logic      cardDetectOne_n,    // Grounded by a seated card
  output logic      cardDetectTwo_n,    // Grounded by a seated card
  output logic      voltageSenseOnePin, // Pulled up in an empty socket
  output logic      voltageSenseTwoPin  // Pulled up in an empty socket
);
  // Both detect contacts move together; a staggered insertion is not
  // modelled, so each insertion or removal gives exactly one change
  assign cardDetectOne_n = ~seated;
  assign cardDetectTwo_n = ~seated;
  // Sense lines fall back to their pull-ups once the card is out
  assign voltageSenseOnePin = seated ? vsOneCode : 1'b1;
  assign voltageSenseTwoPin = seated ? vsTwoCode : 1'b1;
endmodule // sdg_card_model
`default_nettype wire

// ===== verif/sdg_socket_detect_global_ctrl_tb_top.sv
// Self-checking bench for the detect/control and global control pair.
// Assumes the card model on the pins and a register model kept here.
`timescale 1ns/100ps
`default_nettype none
module sdg_socket_detect_global_ctrl_tb_top
  import sdg_pkg::*;
;
  logic        clk = 1'b0;          // 100 MHz clock
  logic        reset_n = 1'b0;      // Asynchronous reset
  logic        regSelect = 1'b0;    // Register strobe
  logic        regWrite = 1'b0;     // Write when high
  logic [7:0]  regAddr = 8'h00;     // Offset
  logic [7:0]  regWriteData = 8'h00;
  logic        cardCycleActive = 1'b0;
  logic        cardDetectIrqEnable = 1'b0;
  logic        statusChangeFlag = 1'b0;
  logic        seated = 1'b1;       // Card model control
  logic        vsOneCode = 1'b0;
  logic        vsTwoCode = 1'b1;
  logic [7:0]  regReadData;
  logic        regReadValid;
  logic        voltageSenseOnePin;
  logic        voltageSenseTwoPin;
  logic        cardDetectOne_n;
  logic        cardDetectTwo_n;
  logic        cardOutputEnable_n;
  logic        ringIndicateOutput_n;
  logic        softCardDetectIrq;
  logic        cardDetectChange;
  logic        legacyRegsReset;
  logic        secondCardIrqLevelSel;
  logic        firstCardIrqLevelSel;
  logic        flagClearMethodSel;
  logic        statusChangeIrqLevelSel;
  logic        cardPowerDown;
  wire logic [4:0] modeBits;        // Mode outputs in register order
  logic [7:0]  mDc = 8'h00;         // Model: writable detect bits
  logic [4:0]  mGc = 5'h00;         // Model: global control bits
  logic        ringExp = 1'b1;      // Model: expected ring level
  logic [31:0] rngState = 32'h95E9; // Fixed seed
  logic [31:0] rnd;
  logic [7:0]  addr;
  logic [7:0]  addrTab [3];         // Both registers and an unmapped one
  int          nMismatch = 0;
  int          checksDone = 0;

  assign modeBits = {secondCardIrqLevelSel, firstCardIrqLevelSel,
                     flagClearMethodSel, statusChangeIrqLevelSel,
                     cardPowerDown};

  // Free-running clock
  always #5 clk = ~clk;

  sdg_card_model u_sdg_card_model (
    .seated             (seated),
    .vsOneCode          (vsOneCode),
    .vsTwoCode          (vsTwoCode),
    .cardDetectOne_n    (cardDetectOne_n),
    .cardDetectTwo_n    (cardDetectTwo_n),
    .voltageSenseOnePin (voltageSenseOnePin),
    .voltageSenseTwoPin (voltageSenseTwoPin)
  );

  sdg_socket_detect_global_ctrl u_sdg_socket_detect_global_ctrl (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .regSelect               (regSelect),
    .regWrite                (regWrite),
    .regAddr                 (regAddr),
    .regWriteData            (regWriteData),
    .regReadData             (regReadData),
    .regReadValid            (regReadValid),
    .voltageSenseOnePin      (voltageSenseOnePin),
    .voltageSenseTwoPin      (voltageSenseTwoPin),
    .cardDetectOne_n         (cardDetectOne_n),
    .cardDetectTwo_n         (cardDetectTwo_n),
    .cardCycleActive         (cardCycleActive),
    .cardOutputEnable_n      (cardOutputEnable_n),
    .ringIndicateOutput_n    (ringIndicateOutput_n),
    .cardDetectIrqEnable     (cardDetectIrqEnable),
    .statusChangeFlag        (statusChangeFlag),
    .softCardDetectIrq       (softCardDetectIrq),
    .cardDetectChange        (cardDetectChange),
    .legacyRegsReset         (legacyRegsReset),
    .secondCardIrqLevelSel   (secondCardIrqLevelSel),
    .firstCardIrqLevelSel    (firstCardIrqLevelSel),
    .flagClearMethodSel      (flagClearMethodSel),
    .statusChangeIrqLevelSel (statusChangeIrqLevelSel),
    .cardPowerDown           (cardPowerDown)
  );

  // Inputs always move 1 ns after the edge, so samples never race
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chkByte(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Zero extension keeps an unknown bit unknown
  task automatic chkBit(input string what, input logic exp, input logic got);
    chkByte(what, {7'h00, exp}, {7'h00, got});
  endtask

  function automatic logic [31:0] xs();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  // Expected detect register: live sense levels over the writable bits
  function automatic logic [7:0] expDc();
    return {voltageSenseTwoPin, voltageSenseOnePin, 6'h00} | mDc;
  endfunction

  // The strobe is left high; the next task sets it, so back to back works
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    regSelect = 1'b1;
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    tick();
    if (a == SDG_DETECT_CTRL_OFFSET) mDc = d & 8'h12;
    if (a == SDG_GLOBAL_CTRL_OFFSET) mGc = d[4:0];
    chkBit("soft irq", (a == SDG_DETECT_CTRL_OFFSET) && d[5] &&
           cardDetectIrqEnable, softCardDetectIrq);
    chkByte("modes", {3'h0, mGc}, {3'h0, modeBits});
    chkBit("power down", mGc[0], cardPowerDown);
  endtask

  task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
    regSelect = 1'b1;
    regWrite = 1'b0;
    regAddr = a;
    tick();
    chkBit("read valid", 1'b1, regReadValid);
    chkByte("read data", exp, regReadData);
  endtask

  task automatic idle(input int n);
    regSelect = 1'b0;
    repeat (n) tick();
  endtask

  // Card change: pulse after the first edge; removal reset one edge later
  task automatic seatTo(input logic s);
    logic removal;
    removal = seated && !s && mDc[1];
    regSelect = 1'b0;
    seated = s;
    chkBit("early change", 1'b0, cardDetectChange);
    tick();
    chkBit("change", 1'b1, cardDetectChange);
    if (mDc[4]) ringExp = 1'b0;
    chkBit("ring", ringExp, ringIndicateOutput_n);
    tick();
    chkBit("change end", 1'b0, cardDetectChange);
    chkBit("removal reset", removal, legacyRegsReset);
    if (removal) mDc = 8'h00;
    if (removal) mGc = 5'h00;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    #900000;
    nMismatch++;
    close_out();
  end

  // Main sequence
  initial
  begin
    addrTab = '{SDG_DETECT_CTRL_OFFSET, SDG_GLOBAL_CTRL_OFFSET, 8'h05};
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    tick();
    chkBit("ring idle", 1'b1, ringIndicateOutput_n);
    regRd(SDG_DETECT_CTRL_OFFSET, expDc());
    regRd(SDG_GLOBAL_CTRL_OFFSET, 8'h00);
    // Random back-to-back writes and reads, unmapped offset among them
    for (int i = 0; i < 24; i++)
    begin
      rnd = xs();
      vsOneCode = rnd[8];
      vsTwoCode = rnd[9];
      cardDetectIrqEnable = rnd[10];
      addr = addrTab[(rnd >> 11) % 3];
      regWr(addr, rnd[7:0]);
      regRd(addr, addr == SDG_DETECT_CTRL_OFFSET ? expDc() :
            addr == SDG_GLOBAL_CTRL_OFFSET ? {3'h0, mGc} : 8'h00);
    end
    // Resume enabled: ring held low until the flag falls
    regWr(SDG_DETECT_CTRL_OFFSET, 8'h10);
    statusChangeFlag = 1'b1;
    seatTo(1'b0);
    regRd(SDG_DETECT_CTRL_OFFSET, expDc());
    idle(3);
    chkBit("ring held", 1'b0, ringIndicateOutput_n);
    statusChangeFlag = 1'b0;
    chkBit("ring release", 1'b0, ringIndicateOutput_n);
    idle(1);
    ringExp = 1'b1;
    chkBit("ring free", 1'b1, ringIndicateOutput_n);
    // Power-down: outputs float except during a card cycle
    regWr(SDG_GLOBAL_CTRL_OFFSET, 8'hFF);
    idle(1);
    chkBit("float", 1'b1, cardOutputEnable_n);
    cardCycleActive = 1'b1;
    idle(3);
    chkBit("driven", 1'b0, cardOutputEnable_n);
    cardCycleActive = 1'b0;
    idle(1);
    chkBit("float again", 1'b1, cardOutputEnable_n);
    cardDetectIrqEnable = 1'b1;
    regWr(SDG_DETECT_CTRL_OFFSET, 8'h22);
    idle(1);
    chkBit("soft irq end", 1'b0, softCardDetectIrq);
    seatTo(1'b1);
    // Removal with reset-on-removal clears both registers
    seatTo(1'b0);
    regRd(SDG_DETECT_CTRL_OFFSET, expDc());
    regRd(SDG_GLOBAL_CTRL_OFFSET, 8'h00);
    idle(2);
    close_out();
  end
endmodule // sdg_socket_detect_global_ctrl_tb_top
`default_nettype wire
